/* rate_conv_pkg.sv */
// Constants, carrier types and helpers for the attenuation, ratio and page register slice
// Functional notes
// - Ganging bit 0: left output scaled by the left attenuation code only.
// - Ganging bit 1: left code also scales right; right code ignored.
// - Ganging bit 0: right output scaled by its own code at 0x31.
// - Attenuation is code value times 0.5 dB; code 0 passes unchanged.
// - Ratio: integer in 0x32 bits 7:3, fraction spans 0x32 bits 2:0 and 0x33.
// - Page register at 0x7F: two-bit page, upper bits zero, page 0 default.
// - Page 1 shows receiver status bytes: channel 1 at 2n, channel 2 at 2n+1.
// - First bit of byte 0 selects consumer (0) or professional (1) format.
// - Professional format: transmitter inserts CRC as byte 23 of each channel.
package rate_conv_pkg;

  localparam int          ADDR_W          = 9;
  localparam int          IDX_W           = 7;
  localparam int          BUF_ADDR_W      = 6;
  localparam int          CS_DEPTH        = 48;
  localparam logic [6:0]  IDX_CONTROL     = 7'h2d;
  localparam logic [6:0]  IDX_LEFT_ATTEN  = 7'h30;
  localparam logic [6:0]  IDX_RIGHT_ATTEN = 7'h31;
  localparam logic [6:0]  IDX_RATIO_HIGH  = 7'h32;
  localparam logic [6:0]  IDX_RATIO_LOW   = 7'h33;
  localparam logic [6:0]  IDX_PAGE        = 7'h7f;
  localparam logic [6:0]  IDX_BUF_LAST    = 7'h2f;
  localparam int          GANG_BIT        = 0;
  localparam int          PRO_BIT         = 7;
  localparam logic [1:0]  PAGE_CONTROL    = 2'h0;
  localparam logic [1:0]  PAGE_RECEIVER   = 2'h1;
  localparam logic [1:0]  PAGE_TRANSMIT   = 2'h2;
  localparam logic [1:0]  PAGE_RESET      = 2'h0;
  localparam logic [7:0]  ATTEN_RESET     = 8'h00;
  localparam logic        GANG_RESET      = 1'b0;
  localparam logic [4:0]  CRC_BYTE        = 5'h17;
  localparam logic [7:0]  CRC_INIT        = 8'hff;
  localparam logic [7:0]  CRC_POLY        = 8'h1d;
  localparam int          GAIN_FRAC       = 15;
  localparam int          STEPS_PER_SHIFT = 12;
  localparam logic [15:0] UNITY_GAIN      = 16'h8000;
  // Gain of 10^(-r/40) in Q15 for r = 0..11; each twelve steps is one right shift
  localparam logic [15:0] GAIN_TABLE [STEPS_PER_SHIFT] = '{
    16'h8000, 16'h78d7, 16'h7215, 16'h6bb3, 16'h65ad, 16'h5ffd,
    16'h5a9e, 16'h558c, 16'h50c3, 16'h4c3f, 16'h47fb, 16'h43f4};

  typedef enum logic [2:0] {
    BUS_IDLE  = 3'b001,
    BUS_FETCH = 3'b010,
    BUS_LOAD  = 3'b100
  } bus_state_type;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_type;

  typedef struct packed {
    logic               valid;
    logic signed [23:0] left;
    logic signed [23:0] right;
  } sample_type;

  typedef struct packed {
    logic [4:0]  shift;
    logic [15:0] gain;
  } atten_type;

  function automatic atten_type atten_split(input logic [7:0] code);
    int        q;
    int        r;
    atten_type res;
    q = int'(code) / STEPS_PER_SHIFT;
    r = int'(code) - q * STEPS_PER_SHIFT;
    res.shift = 5'(q);
    res.gain  = GAIN_TABLE[r];
    return res;
  endfunction : atten_split

  // Bits enter in transmission order, register bit 7 first
  function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    logic       fb;
    c = crc;
    for (int i = 7; i >= 0; i--)
    begin
      fb = c[7] ^ data[i];
      c  = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction : crc8_byte

endpackage : rate_conv_pkg

/* cs_buffer_mem.sv */
// Channel status byte store: one write port, two registered read ports
`timescale 1ns/1ps
module cs_buffer_mem #(
  parameter int WIDTH  = 8,
  parameter int DEPTH  = 48,
  parameter int ADDR_W = 6
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [WIDTH-1:0]  wdata,
  input  wire logic [ADDR_W-1:0] raddr_a,
  output logic      [WIDTH-1:0]  rdata_a,
  input  wire logic [ADDR_W-1:0] raddr_b,
  output logic      [WIDTH-1:0]  rdata_b
);

  if (DEPTH > (1 << ADDR_W) || DEPTH < 1)
  begin : g_bad_depth
    $error("cs_buffer_mem depth does not fit its address width");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  // Contents are data, not control, so they carry no reset
  always_ff @(posedge clk)
  begin
    if (we && int'(waddr) < DEPTH)
      mem[waddr] <= wdata;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_a <= '0;
    else
      rdata_a <= (int'(raddr_a) < DEPTH) ? mem[raddr_a] : '0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_b <= '0;
    else
      rdata_b <= (int'(raddr_b) < DEPTH) ? mem[raddr_b] : '0;
  end

endmodule : cs_buffer_mem

/* rate_conv_regs.sv */
// Paged APB register bank: output attenuation, ratio readback, channel status buffers
`timescale 1ns/1ps
module rate_conv_regs #(
  parameter int CS_DEPTH = rate_conv_pkg::CS_DEPTH
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire rate_conv_pkg::apb_req_type apb_req,
  output rate_conv_pkg::apb_rsp_type   apb_rsp,
  input  wire logic [15:0]             ratio_measured,
  input  wire logic                    rx_cs_we,
  input  wire logic [5:0]              rx_cs_addr,
  input  wire logic [7:0]              rx_cs_wdata,
  output logic      [1:0]              rx_pro_mode,
  input  wire logic                    tx_cs_rd,
  input  wire logic [5:0]              tx_cs_addr,
  output logic      [7:0]              tx_cs_rdata,
  output logic      [1:0]              tx_pro_mode,
  input  wire rate_conv_pkg::sample_type audio_in,
  output rate_conv_pkg::sample_type    audio_out
);

  if (CS_DEPTH != 2 * 24)
  begin : g_bad_depth
    $error("rate_conv_regs needs 24 status bytes per channel");
  end

  rate_conv_pkg::bus_state_type bus_state_reg;
  rate_conv_pkg::bus_state_type bus_state_next;
  logic [6:0]                   idx;
  logic                         wr_fire;
  logic                         rd_load;
  logic [1:0]                   page_reg;
  logic                         gang_reg;
  logic [7:0]                   atten_code_reg [2];
  logic [15:0]                  ratio_hold_reg;
  logic [31:0]                  prdata_reg;
  logic [31:0]                  read_value;
  logic [7:0]                   rx_mem_rdata;
  logic [7:0]                   tx_mem_rdata;
  logic [7:0]                   tx_b_rdata;
  logic                         tx_mem_we;
  logic                         tx_rd_d_reg;
  logic [5:0]                   tx_addr_d_reg;
  logic [4:0]                   tx_byte;
  logic                         tx_ch;
  logic [7:0]                   crc_reg [2];
  logic [1:0]                   tx_pro_reg;
  logic [1:0]                   rx_pro_reg;
  logic [7:0]                   tx_rdata_reg;
  rate_conv_pkg::atten_type     split_reg [2];
  logic signed [40:0]           prod_reg [2];
  logic [4:0]                   shift_d_reg [2];
  logic                         stage_valid_reg;
  logic signed [23:0]           out_reg [2];
  logic                         out_valid_reg;
  logic signed [23:0]           in_sample [2];

  function automatic logic in_buffer(input logic [6:0] i);
    return i <= rate_conv_pkg::IDX_BUF_LAST;
  endfunction : in_buffer

  function automatic logic is_mapped(input logic [1:0] pg, input logic [6:0] i,
                                     input logic [1:0] low);
    logic ctl;
    ctl = (i == rate_conv_pkg::IDX_CONTROL) || (i == rate_conv_pkg::IDX_LEFT_ATTEN) ||
          (i == rate_conv_pkg::IDX_RIGHT_ATTEN) || (i == rate_conv_pkg::IDX_RATIO_HIGH) ||
          (i == rate_conv_pkg::IDX_RATIO_LOW);
    if (low != 2'h0)
      return 1'b0;
    if (i == rate_conv_pkg::IDX_PAGE)
      return 1'b1;
    if (pg == rate_conv_pkg::PAGE_CONTROL)
      return ctl;
    if (pg == rate_conv_pkg::PAGE_RECEIVER || pg == rate_conv_pkg::PAGE_TRANSMIT)
      return in_buffer(i);
    return 1'b0;
  endfunction : is_mapped

  assign idx     = apb_req.paddr[8:2];
  assign wr_fire = (bus_state_reg == rate_conv_pkg::BUS_LOAD) && apb_req.psel &&
                   apb_req.penable && apb_req.pwrite;
  assign rd_load = (bus_state_reg == rate_conv_pkg::BUS_FETCH) && !apb_req.pwrite;

  // Two wait states: the buffer read is registered, then the read word is registered
  always_comb
  begin
    bus_state_next = bus_state_reg;
    case (bus_state_reg)
      rate_conv_pkg::BUS_IDLE:
        if (apb_req.psel && apb_req.penable)
          bus_state_next = rate_conv_pkg::BUS_FETCH;
      rate_conv_pkg::BUS_FETCH:
        bus_state_next = rate_conv_pkg::BUS_LOAD;
      rate_conv_pkg::BUS_LOAD:
        bus_state_next = rate_conv_pkg::BUS_IDLE;
      default:
        bus_state_next = rate_conv_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      bus_state_reg <= rate_conv_pkg::BUS_IDLE;
    else
      bus_state_reg <= bus_state_next;
  end

  assign apb_rsp.prdata  = prdata_reg;
  assign apb_rsp.pready  = (bus_state_reg == rate_conv_pkg::BUS_LOAD) && apb_req.penable;
  assign apb_rsp.pslverr = apb_rsp.pready && !is_mapped(page_reg, idx, apb_req.paddr[1:0]);

  always_comb
  begin
    read_value = 32'h0000_0000;
    if (!is_mapped(page_reg, idx, apb_req.paddr[1:0]))
      read_value = 32'h0000_0000;
    else if (idx == rate_conv_pkg::IDX_PAGE)
      read_value = {30'h0000_0000, page_reg};
    else
      case (page_reg)
        rate_conv_pkg::PAGE_CONTROL:
          case (idx)
            rate_conv_pkg::IDX_CONTROL:     read_value[rate_conv_pkg::GANG_BIT] = gang_reg;
            rate_conv_pkg::IDX_LEFT_ATTEN:  read_value[7:0] = atten_code_reg[0];
            rate_conv_pkg::IDX_RIGHT_ATTEN: read_value[7:0] = atten_code_reg[1];
            rate_conv_pkg::IDX_RATIO_HIGH:  read_value[7:0] = ratio_measured[15:8];
            rate_conv_pkg::IDX_RATIO_LOW:   read_value[7:0] = ratio_hold_reg[7:0];
            default:                        read_value = 32'h0000_0000;
          endcase
        rate_conv_pkg::PAGE_RECEIVER: read_value[7:0] = rx_mem_rdata;
        rate_conv_pkg::PAGE_TRANSMIT: read_value[7:0] = tx_mem_rdata;
        default:                      read_value = 32'h0000_0000;
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      prdata_reg <= 32'h0000_0000;
    else if (rd_load)
      prdata_reg <= read_value;
  end

  // Freezing here means the fraction low byte always matches the high byte just read
  always_ff @(posedge clk)
  begin
    if (rst)
      ratio_hold_reg <= 16'h0000;
    else if (rd_load && page_reg == rate_conv_pkg::PAGE_CONTROL &&
             idx == rate_conv_pkg::IDX_RATIO_HIGH && apb_req.paddr[1:0] == 2'h0)
      ratio_hold_reg <= ratio_measured;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      page_reg <= rate_conv_pkg::PAGE_RESET;
    else if (wr_fire && idx == rate_conv_pkg::IDX_PAGE && apb_req.paddr[1:0] == 2'h0)
      page_reg <= apb_req.pwdata[1:0];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      gang_reg          <= rate_conv_pkg::GANG_RESET;
      atten_code_reg[0] <= rate_conv_pkg::ATTEN_RESET;
      atten_code_reg[1] <= rate_conv_pkg::ATTEN_RESET;
    end
    else if (wr_fire && page_reg == rate_conv_pkg::PAGE_CONTROL &&
             apb_req.paddr[1:0] == 2'h0)
    begin
      if (idx == rate_conv_pkg::IDX_CONTROL)
        gang_reg <= apb_req.pwdata[rate_conv_pkg::GANG_BIT];
      if (idx == rate_conv_pkg::IDX_LEFT_ATTEN)
        atten_code_reg[0] <= apb_req.pwdata[7:0];
      if (idx == rate_conv_pkg::IDX_RIGHT_ATTEN)
        atten_code_reg[1] <= apb_req.pwdata[7:0];
    end
  end

  assign tx_mem_we = wr_fire && page_reg == rate_conv_pkg::PAGE_TRANSMIT &&
                     in_buffer(idx) && apb_req.paddr[1:0] == 2'h0;

  // Receiver buffer is read-only to software; only the receiver fills it
  cs_buffer_mem #(
    .WIDTH  (8),
    .DEPTH  (CS_DEPTH),
    .ADDR_W (rate_conv_pkg::BUF_ADDR_W)
  ) rx_buffer (
    .clk     (clk),
    .rst     (rst),
    .we      (rx_cs_we),
    .waddr   (rx_cs_addr),
    .wdata   (rx_cs_wdata),
    .raddr_a (idx[5:0]),
    .rdata_a (rx_mem_rdata),
    .raddr_b (6'h00),
    .rdata_b ()
  );

  cs_buffer_mem #(
    .WIDTH  (8),
    .DEPTH  (CS_DEPTH),
    .ADDR_W (rate_conv_pkg::BUF_ADDR_W)
  ) tx_buffer (
    .clk     (clk),
    .rst     (rst),
    .we      (tx_mem_we),
    .waddr   (idx[5:0]),
    .wdata   (apb_req.pwdata[7:0]),
    .raddr_a (idx[5:0]),
    .rdata_a (tx_mem_rdata),
    .raddr_b (tx_cs_addr),
    .rdata_b (tx_b_rdata)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tx_rd_d_reg   <= 1'b0;
      tx_addr_d_reg <= 6'h00;
    end
    else
    begin
      tx_rd_d_reg   <= tx_cs_rd;
      tx_addr_d_reg <= tx_cs_addr;
    end
  end

  assign tx_byte = tx_addr_d_reg[5:1];
  assign tx_ch   = tx_addr_d_reg[0];

  // CRC runs as the transmitter walks bytes 0..22, so bytes must be fetched in order
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_chan
    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        crc_reg[ch]    <= rate_conv_pkg::CRC_INIT;
        tx_pro_reg[ch] <= 1'b0;
      end
      else if (tx_rd_d_reg && tx_ch == 1'(ch))
      begin
        if (tx_byte == 5'h00)
        begin
          crc_reg[ch]    <= rate_conv_pkg::crc8_byte(rate_conv_pkg::CRC_INIT, tx_b_rdata);
          tx_pro_reg[ch] <= tx_b_rdata[rate_conv_pkg::PRO_BIT];
        end
        else if (tx_byte < rate_conv_pkg::CRC_BYTE)
          crc_reg[ch] <= rate_conv_pkg::crc8_byte(crc_reg[ch], tx_b_rdata);
      end
    end

    always_ff @(posedge clk)
    begin
      if (rst)
        rx_pro_reg[ch] <= 1'b0;
      else if (rx_cs_we && rx_cs_addr == 6'(ch))
        rx_pro_reg[ch] <= rx_cs_wdata[rate_conv_pkg::PRO_BIT];
    end

    // Right channel follows the left code while ganged
    always_ff @(posedge clk)
    begin
      if (rst)
        split_reg[ch] <= rate_conv_pkg::atten_split(rate_conv_pkg::ATTEN_RESET);
      else if (ch == 1 && gang_reg)
        split_reg[ch] <= rate_conv_pkg::atten_split(atten_code_reg[0]);
      else
        split_reg[ch] <= rate_conv_pkg::atten_split(atten_code_reg[ch]);
    end

    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        prod_reg[ch]    <= '0;
        shift_d_reg[ch] <= 5'h00;
        out_reg[ch]     <= 24'sh000000;
      end
      else
      begin
        if (audio_in.valid)
        begin
          prod_reg[ch]    <= in_sample[ch] * $signed({1'b0, split_reg[ch].gain});
          shift_d_reg[ch] <= split_reg[ch].shift;
        end
        if (stage_valid_reg)
          out_reg[ch] <= 24'(prod_reg[ch] >>> (rate_conv_pkg::GAIN_FRAC +
                                               int'(shift_d_reg[ch])));
      end
    end
  end

  assign in_sample[0] = audio_in.left;
  assign in_sample[1] = audio_in.right;

  always_ff @(posedge clk)
  begin
    if (rst)
      tx_rdata_reg <= 8'h00;
    else if (tx_rd_d_reg && tx_byte == rate_conv_pkg::CRC_BYTE && tx_pro_reg[tx_ch])
      tx_rdata_reg <= crc_reg[tx_ch];
    else if (tx_rd_d_reg)
      tx_rdata_reg <= tx_b_rdata;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage_valid_reg <= 1'b0;
      out_valid_reg   <= 1'b0;
    end
    else
    begin
      stage_valid_reg <= audio_in.valid;
      out_valid_reg   <= stage_valid_reg;
    end
  end

  assign tx_cs_rdata     = tx_rdata_reg;
  assign tx_pro_mode     = tx_pro_reg;
  assign rx_pro_mode     = rx_pro_reg;
  assign audio_out.valid = out_valid_reg;
  assign audio_out.left  = out_reg[0];
  assign audio_out.right = out_reg[1];

  AST_LEFT_OWN_CODE: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> split_reg[0] == rate_conv_pkg::atten_split($past(atten_code_reg[0])))
    else $error("left gain does not follow left code");

  AST_GANG_RIGHT: assert property (@(posedge clk) disable iff (rst)
    gang_reg |=> split_reg[1] == rate_conv_pkg::atten_split($past(atten_code_reg[0])))
    else $error("ganged right gain differs from left code");

  AST_RIGHT_OWN_CODE: assert property (@(posedge clk) disable iff (rst)
    !gang_reg |=> split_reg[1] == rate_conv_pkg::atten_split($past(atten_code_reg[1])))
    else $error("right gain does not follow right code");

  AST_UNITY_PASS: assert property (@(posedge clk) disable iff (rst)
    audio_in.valid && split_reg[0].gain == rate_conv_pkg::UNITY_GAIN &&
    split_reg[0].shift == 5'h00 |-> ##2 out_valid_reg && out_reg[0] == $past(audio_in.left, 2))
    else $error("zero attenuation changed the sample");

  AST_RATIO_HIGH: assert property (@(posedge clk) disable iff (rst)
    $rose(bus_state_reg == rate_conv_pkg::BUS_LOAD) && ratio_hold_reg != $past(ratio_hold_reg)
    |-> prdata_reg[7:0] == ratio_hold_reg[15:8] && prdata_reg[31:8] == 24'h000000)
    else $error("ratio high byte does not match captured ratio");

  AST_RATIO_LOW: assert property (@(posedge clk) disable iff (rst)
    rd_load && page_reg == rate_conv_pkg::PAGE_CONTROL && idx == rate_conv_pkg::IDX_RATIO_LOW &&
    apb_req.paddr[1:0] == 2'h0 |=> prdata_reg[7:0] == $past(ratio_hold_reg[7:0]))
    else $error("ratio low byte not from holding register");

  AST_PAGE_WRITE: assert property (@(posedge clk) disable iff (rst)
    wr_fire && idx == rate_conv_pkg::IDX_PAGE && apb_req.paddr[1:0] == 2'h0
    |=> page_reg == $past(apb_req.pwdata[1:0]) ##1 bus_state_reg == rate_conv_pkg::BUS_IDLE)
    else $error("page write not taken");

  AST_PAGE_READ_ZERO: assert property (@(posedge clk) disable iff (rst)
    rd_load && idx == rate_conv_pkg::IDX_PAGE && apb_req.paddr[1:0] == 2'h0
    |=> prdata_reg[31:2] == 30'h0000_0000 && apb_rsp.pready == apb_req.penable)
    else $error("page read shows upper bits");

  AST_PRO_FLAG: assert property (@(posedge clk) disable iff (rst)
    tx_rd_d_reg && tx_byte == 5'h00 |=> tx_pro_reg[$past(tx_ch)] == $past(tx_b_rdata[7]))
    else $error("format flag not taken from byte 0");

  AST_CRC_INSERT: assert property (@(posedge clk) disable iff (rst)
    tx_rd_d_reg && tx_byte == rate_conv_pkg::CRC_BYTE && tx_pro_reg[tx_ch]
    |=> tx_cs_rdata == $past(crc_reg[tx_ch]))
    else $error("crc not inserted as byte 23");

endmodule : rate_conv_regs

/* tb_rate_conv_atten_ratio_page_regs.sv */
// Self-checking bench for the paged attenuation, ratio and buffer registers
`timescale 1ns/1ps
module tb_rate_conv_atten_ratio_page_regs;
  `define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

  logic                       clk = 1'b0;
  logic                       rst = 1'b1;
  rate_conv_pkg::apb_req_type req = '0;
  rate_conv_pkg::apb_rsp_type rsp;
  logic [15:0]                ratio = 16'h0000;
  logic                       rx_we = 1'b0;
  logic [5:0]                 rx_addr = 6'h00;
  logic [7:0]                 rx_data = 8'h00;
  logic [1:0]                 rx_pro;
  logic                       tx_rd = 1'b0;
  logic [5:0]                 tx_addr = 6'h00;
  logic [7:0]                 tx_data;
  logic [1:0]                 tx_pro;
  rate_conv_pkg::sample_type  ain = '0;
  rate_conv_pkg::sample_type  aout;
  int                         num_errors = 0;
  int                         checks = 0;
  logic [31:0]                rd;
  logic                       err;
  logic [7:0]                 rxm [48];
  logic [7:0]                 txm [48];
  logic [7:0]                 crc;
  logic [7:0]                 exp_tx;
  logic [15:0]                hold;
  int                         gain_exp;
  int                         gain_err;
  int                         gang [3] = '{0, 0, 1};
  int                         lcode [3] = '{0, 12, 36};
  int                         rcode [3] = '{24, 0, 0};

  always #4 clk = ~clk;

  rate_conv_regs #(.CS_DEPTH(48)) dut_u (
    .clk            (clk),
    .rst            (rst),
    .apb_req        (req),
    .apb_rsp        (rsp),
    .ratio_measured (ratio),
    .rx_cs_we       (rx_we),
    .rx_cs_addr     (rx_addr),
    .rx_cs_wdata    (rx_data),
    .rx_pro_mode    (rx_pro),
    .tx_cs_rd       (tx_rd),
    .tx_cs_addr     (tx_addr),
    .tx_cs_rdata    (tx_data),
    .tx_pro_mode    (tx_pro),
    .audio_in       (ain),
    .audio_out      (aout)
  );

  // Response taken at the very edge pready is sampled high; release follows at once
  task automatic apb(input logic w, input logic [8:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 50);
    if (rsp.pready !== 1'b1)
    begin
      num_errors++;
      test_done;
    end
    rd          = rsp.prdata;
    err         = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [8:0] a, input logic [31:0] e, input logic x);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
    `CHK(err, x)
  endtask : rdchk

  // Independent bit-serial model, first-sent bit is register bit 7
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
      r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? 8'h1d : 8'h00);
    return r;
  endfunction : crc_step

  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    test_done;
  end

  initial
  begin
    rd = $urandom(61);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdchk(9'h1fc, 32'h0, 1'b0);
    rdchk(9'h0c0, 32'h0, 1'b0);
    rdchk(9'h0c4, 32'h0, 1'b0);
    apb(1'b1, 9'h1fc, 32'hff);
    rdchk(9'h1fc, 32'h3, 1'b0);
    rdchk(9'h0c0, 32'h0, 1'b1);
    apb(1'b1, 9'h1fc, 32'h0);
    rdchk(9'h100, 32'h0, 1'b1);
    rdchk(9'h0c1, 32'h0, 1'b1);
    // Live value moves after the high read; low read must stay with the frozen copy
    ratio <= 16'($urandom);
    @(negedge clk);
    hold = ratio;
    rdchk(9'h0c8, {24'h0, hold[15:8]}, 1'b0);
    ratio <= ~hold;
    apb(1'b1, 9'h0cc, 32'hff);
    rdchk(9'h0cc, {24'h0, hold[7:0]}, 1'b0);
    rcode[2] = 12 * ($urandom % 8);
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b1, 9'h0b4, 32'(gang[k]));
      apb(1'b1, 9'h0c0, 32'(lcode[k]));
      apb(1'b1, 9'h0c4, 32'(rcode[k]));
      rdchk(9'h0b4, 32'(gang[k]), 1'b0);
      rdchk(9'h0c4, 32'(rcode[k]), 1'b0);
      ain.valid <= 1'b1;
      ain.left  <= 24'($urandom);
      ain.right <= 24'($urandom);
      repeat (5) @(posedge clk);
      @(negedge clk);
      `CHK(aout.valid, 1'b1)
      `CHK(aout.left, ain.left >>> (lcode[k] / 12))
      `CHK(aout.right, ain.right >>> ((gang[k] != 0 ? lcode[k] : rcode[k]) / 12))
      @(posedge clk);
      ain.valid <= 1'b0;
    end
    // Off-grid code: exact 10^(-N/40) gain, allowing for table and truncation error
    apb(1'b1, 9'h0c0, 32'h7);
    ain.valid <= 1'b1;
    ain.left  <= 24'($urandom);
    repeat (5) @(posedge clk);
    @(negedge clk);
    gain_exp = $rtoi($itor(ain.left) * (10.0 ** (-7.0 / 40.0)));
    gain_err = int'(aout.left) - gain_exp;
    `CHK(gain_err * gain_err <= (gain_exp / 4096) * (gain_exp / 4096) + 4, 1'b1)
    @(posedge clk);
    ain.valid <= 1'b0;
    for (int i = 0; i < 48; i++)
    begin
      rxm[i] = 8'($urandom);
      txm[i] = 8'($urandom);
    end
    rxm[0][7] = 1'b1;
    rxm[1][7] = 1'b0;
    txm[0][7] = 1'b1;
    txm[1][7] = 1'b0;
    for (int i = 0; i < 48; i++)
    begin
      @(posedge clk);
      rx_we   <= 1'b1;
      rx_addr <= 6'(i);
      rx_data <= rxm[i];
    end
    @(posedge clk);
    rx_we <= 1'b0;
    @(negedge clk);
    `CHK(rx_pro, 2'b01)
    apb(1'b1, 9'h1fc, 32'h1);
    for (int i = 0; i < 48; i++)
      rdchk(9'(4 * i), {24'h0, rxm[i]}, 1'b0);
    apb(1'b1, 9'h000, {24'h0, ~rxm[0]});
    rdchk(9'h000, {24'h0, rxm[0]}, 1'b0);
    apb(1'b1, 9'h1fc, 32'h2);
    for (int i = 0; i < 48; i++)
      apb(1'b1, 9'(4 * i), {24'h0, txm[i]});
    rdchk(9'h008, {24'h0, txm[2]}, 1'b0);
    crc = 8'hff;
    for (int i = 0; i < 48; i++)
    begin
      exp_tx = (i == 46) ? crc : txm[i];
      if (i % 2 == 0 && i < 46)
        crc = crc_step(crc, txm[i]);
      @(posedge clk);
      tx_rd   <= 1'b1;
      tx_addr <= 6'(i);
      @(posedge clk);
      tx_rd <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      `CHK(tx_data, exp_tx)
      if (i == 1)
        `CHK(tx_pro, 2'b01)
    end
    test_done;
  end
endmodule : tb_rate_conv_atten_ratio_page_regs
